// >>> hdl/reset_seq_defs.vh
`ifndef RESET_SEQ_DEFS_VH
`define RESET_SEQ_DEFS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_W            8
`define DATA_W            8
`define ADDR_MON_CTRL     8'hff
`define ADDR_RST_CAUSE    8'hef
`define ADDR_IRQ_STAT     8'hf0
`define ADDR_IRQ_MASK     8'hf1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_MON_EN        7
`define BIT_SUPPLY_STAT   6
`define BIT_PIN_FLAG      0
`define BIT_PWR_FLAG      1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_MON_EN        1'b1
`define RST_PWR_SEL       1'b1
`define RST_PWR_FLAG      1'b1
`define RST_PIN_FLAG      1'b0
`define RST_IRQ_MASK      3'h0
`define RST_DRV_HIST      2'h3
`define RST_BYTE          8'h00

// ----------------------------------------
// Interrupt events
// ----------------------------------------
`define EV_N              3
`define EV_SUPPLY_LOW     0
`define EV_SUPPLY_OK      1
`define EV_PIN_RESET      2

// ----------------------------------------
// Timing
// ----------------------------------------
`define POR_DELAY_CYC     16

`endif

// >>> hdl/level_sync.v
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter       W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input  wire         mclk_i,
  input  wire         rst_n_i,
  // Levels
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // level_sync

`default_nettype wire

// >>> hdl/event_flags.v
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_defs.vh"

module event_flags #(
  parameter N = 3
) (
  // Clock and reset
  input  wire         mclk_i,
  input  wire         rst_n_i,
  // Events
  input  wire [N-1:0] event_i,
  // Software access
  input  wire         clr_wr_i,
  input  wire [N-1:0] clr_data_i,
  input  wire         mask_wr_i,
  input  wire [N-1:0] mask_data_i,
  // Status
  output wire [N-1:0] status_o,
  output wire [N-1:0] mask_o,
  output wire         irq_o
);

  reg  [N-1:0] stat_q;
  reg  [N-1:0] mask_q;

  // ----------------------------------------
  // Sticky flags, set beats clear
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_flag
      always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          stat_q[i] <= 1'b0;
        end else if (event_i[i]) begin
          stat_q[i] <= 1'b1;
        end else if (clr_wr_i && clr_data_i[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= `RST_IRQ_MASK;
    end else if (mask_wr_i) begin
      mask_q <= mask_data_i;
    end
  end

  assign status_o = stat_q;
  assign mask_o   = mask_q;
  assign irq_o    = |(stat_q & mask_q);

endmodule // event_flags

`default_nettype wire

// >>> hdl/reset_seq.v
// Overview of operation
// [R1] Selected monitor trip drives pin, holds core
// [R2] Core released once supply back above threshold
// [R3] Power-on reset sets monitor enable
// [R4] Other resets leave monitor enable alone
// [R5] Software enables monitor before selecting it
// [R6] Enable bit 7; no reset unless selected
// [R7] Bit 6 reads live supply status
// [R8] Control bits 5:0 read zero, ignore writes
// [R9] No power-on delay after monitor reset
// [R10] Low reset pin holds device in reset
// [R11] Pin reset exit sets pin flag
// [R12] Software distrusts memory when power flag set
// [R13] Power flag set on power/monitor, else cleared
// [R14] Sync status inputs; assert reset asynchronously
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_defs.vh"

module reset_seq #(
  parameter POR_DELAY_CYC = `POR_DELAY_CYC,
  parameter CNT_W         = 16
) (
  // Clock and power-on reset
  input  wire                 mclk_i,
  input  wire                 rst_n_i,
  // Supply comparator, high above threshold
  input  wire                 supply_ok_i,
  // Open-drain reset pin
  input  wire                 rst_pin_i,
  output wire                 rst_pin_o,
  output wire                 rst_pin_oe_n_o,
  // Other internal reset requests
  input  wire                 sys_rst_req_i,
  // Core reset
  output wire                 core_rst_n_o,
  // Register port
  input  wire [`ADDR_W-1:0]   addr_i,
  input  wire [`DATA_W-1:0]   wdata_i,
  input  wire                 wr_i,
  input  wire                 rd_i,
  output wire [`DATA_W-1:0]   rdata_o,
  // Interrupt
  output wire                 irq_o
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  localparam integer     POR_LAST_I = POR_DELAY_CYC - 1;
  localparam [CNT_W-1:0] POR_LAST   = POR_LAST_I[CNT_W-1:0];

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg                 supply_enable_q;
  reg                 power_select_q;
  reg                 power_flag_q;
  reg                 pin_flag_q;
  reg  [CNT_W-1:0]    por_cnt_q;
  reg  [CNT_W-1:0]    por_cnt_d;
  reg                 por_done_q;
  reg  [1:0]          release_q;
  reg                 core_prev_q;
  reg                 cause_por_q;
  reg                 cause_mon_q;
  reg                 cause_pin_q;
  reg  [1:0]          drive_hist_q;
  reg                 supply_prev_q;
  reg  [`DATA_W-1:0]  rdata_q;
  reg  [`DATA_W-1:0]  rdata_d;

  wire                supply_s;
  wire                pin_s;
  wire                monitor_trip;
  wire                monitor_trip_s;
  wire                pin_drive;
  wire                pin_drive_s;
  wire                pin_ext_low;
  wire                pin_ext_low_s;
  wire                reset_any;
  wire                in_reset;
  wire                reset_exit;
  wire [`EV_N-1:0]    events;
  wire [`EV_N-1:0]    irq_status;
  wire [`EV_N-1:0]    irq_mask;
  wire                wr_ctrl;
  wire                wr_cause;
  wire                wr_istat;
  wire                wr_imask;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Supply assumed good and pin high until seen otherwise
  level_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_in_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i ({supply_ok_i, rst_pin_i}),
    .sync_o  ({supply_s, pin_s})
  ); // see [R14]

  // ----------------------------------------
  // Asynchronous reset sources
  // ----------------------------------------
  // Trip only when enabled and also selected
  assign monitor_trip = supply_enable_q & power_select_q & ~supply_ok_i; // see [R6]

  // Pin driven low for monitor trip and power-on
  assign pin_drive = monitor_trip | ~por_done_q; // see [R1]

  assign rst_pin_o      = 1'b0;
  assign rst_pin_oe_n_o = ~pin_drive; // see [R1]

  // Own drive on the pin is not an external reset
  assign pin_ext_low = ~rst_pin_i & ~pin_drive; // see [R10]

  // Raw sources act at once; nothing waits for a clock
  assign reset_any = ~rst_n_i
                   | ~por_done_q
                   | monitor_trip
                   | pin_ext_low
                   | sys_rst_req_i; // see [R14]

  // ----------------------------------------
  // Power-on delay
  // ----------------------------------------
  // Only the power-on path counts; a monitor trip skips this
  always @* begin
    por_cnt_d = por_cnt_q;
    if (!por_done_q) begin
      por_cnt_d = por_cnt_q + 1'b1;
    end
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_cnt_q  <= {CNT_W{1'b0}};
      por_done_q <= 1'b0;
    end else begin
      por_cnt_q <= por_cnt_d;
      if (por_cnt_q == POR_LAST) begin
        por_done_q <= 1'b1; // see [R9]
      end
    end
  end

  // ----------------------------------------
  // Core reset: async assert, sync release
  // ----------------------------------------
  // Two-cycle release avoids a runt edge on the core
  always @(posedge mclk_i or posedge reset_any) begin
    if (reset_any) begin
      release_q <= 2'h0; // see [R1] [R10]
    end else begin
      release_q <= {release_q[0], 1'b1}; // see [R2] [R9]
    end
  end

  assign core_rst_n_o = release_q[1];
  assign in_reset     = ~release_q[1];

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_prev_q <= 1'b0;
    end else begin
      core_prev_q <= release_q[1];
    end
  end

  assign reset_exit = release_q[1] & ~core_prev_q;

  // ----------------------------------------
  // Cause capture
  // ----------------------------------------
  assign monitor_trip_s = supply_enable_q & power_select_q & ~supply_s;
  assign pin_drive_s    = monitor_trip_s | ~por_done_q;
  assign pin_ext_low_s  = ~pin_s & ~pin_drive_s & ~(|drive_hist_q); // see [R11]

  // Own release reaches pin_s two edges late; mask that tail
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_hist_q <= `RST_DRV_HIST;
    end else begin
      drive_hist_q <= {drive_hist_q[0], pin_drive_s};
    end
  end

  // Pin pulses shorter than the synchroniser may go unrecorded
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cause_por_q <= 1'b1;
      cause_mon_q <= 1'b0;
      cause_pin_q <= 1'b0;
    end else if (reset_exit) begin
      cause_por_q <= 1'b0;
      cause_mon_q <= 1'b0;
      cause_pin_q <= 1'b0;
    end else if (in_reset) begin
      if (monitor_trip_s) begin
        cause_mon_q <= 1'b1;
      end
      if (pin_ext_low_s) begin
        cause_pin_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Reset cause flags
  // ----------------------------------------
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_flag_q <= `RST_PWR_FLAG;
      pin_flag_q   <= `RST_PIN_FLAG;
    end else if (reset_exit) begin
      power_flag_q <= cause_por_q | cause_mon_q; // see [R13] [R12]
      pin_flag_q   <= cause_pin_q; // see [R11]
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  assign wr_ctrl  = wr_i & hit(addr_i, `ADDR_MON_CTRL);
  assign wr_cause = wr_i & hit(addr_i, `ADDR_RST_CAUSE);
  assign wr_istat = wr_i & hit(addr_i, `ADDR_IRQ_STAT);
  assign wr_imask = wr_i & hit(addr_i, `ADDR_IRQ_MASK);

  // Only the power-on reset touches these two
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supply_enable_q <= `RST_MON_EN; // see [R3]
      power_select_q  <= `RST_PWR_SEL;
    end else begin
      if (wr_ctrl) begin
        supply_enable_q <= wdata_i[`BIT_MON_EN]; // see [R4] [R8]
      end
      // Selecting before the monitor settles may trip a reset
      if (wr_cause) begin
        power_select_q <= wdata_i[`BIT_PWR_FLAG]; // see [R5]
      end
    end
  end

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supply_prev_q <= 1'b1;
    end else begin
      supply_prev_q <= supply_s;
    end
  end

  assign events[`EV_SUPPLY_LOW] = supply_prev_q & ~supply_s;
  assign events[`EV_SUPPLY_OK]  = ~supply_prev_q & supply_s;
  assign events[`EV_PIN_RESET]  = reset_exit & cause_pin_q;

  event_flags #(
    .N (`EV_N)
  ) u_flags (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .event_i     (events),
    .clr_wr_i    (wr_istat),
    .clr_data_i  (wdata_i[`EV_N-1:0]),
    .mask_wr_i   (wr_imask),
    .mask_data_i (wdata_i[`EV_N-1:0]),
    .status_o    (irq_status),
    .mask_o      (irq_mask),
    .irq_o       (irq_o)
  );

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always @* begin
    rdata_d = `RST_BYTE; // see [R8]
    if (rd_i) begin
      if (hit(addr_i, `ADDR_MON_CTRL)) begin
        rdata_d[`BIT_MON_EN]      = supply_enable_q;
        rdata_d[`BIT_SUPPLY_STAT] = supply_s; // see [R7]
      end else if (hit(addr_i, `ADDR_RST_CAUSE)) begin
        rdata_d[`BIT_PWR_FLAG] = power_flag_q; // see [R13]
        rdata_d[`BIT_PIN_FLAG] = pin_flag_q; // see [R11]
      end else if (hit(addr_i, `ADDR_IRQ_STAT)) begin
        rdata_d[`EV_N-1:0] = irq_status;
      end else if (hit(addr_i, `ADDR_IRQ_MASK)) begin
        rdata_d[`EV_N-1:0] = irq_mask;
      end
    end
  end

  // Data stands one cycle only, zero otherwise
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= `RST_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

endmodule // reset_seq

`default_nettype wire

// >>> test/reset_seq_props.sv
`timescale 1ns/1ps
`default_nettype none

module reset_seq_props (
  // Clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  // Inputs
  input wire logic       supply_ok_i,
  input wire logic       rst_pin_i,
  input wire logic       sys_rst_req_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  // Outputs
  input wire logic       rst_pin_o,
  input wire logic       rst_pin_oe_n_o,
  input wire logic       core_rst_n_o,
  input wire logic [7:0] rdata_o,
  input wire logic       irq_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_rd_ctrl;
    rd_i && addr_i == 8'hff;
  endsequence
  // Margin of one edge over the release path
  sequence s_quiet;
    (rst_pin_oe_n_o && rst_pin_i && supply_ok_i && !sys_rst_req_i) [*4];
  endsequence

  property p_drive_holds; !rst_pin_oe_n_o |-> !core_rst_n_o; endproperty
  property p_pin_holds;   !rst_pin_i |-> !core_rst_n_o; endproperty
  property p_req_holds;   sys_rst_req_i |-> !core_rst_n_o; endproperty
  property p_release;     s_quiet |-> core_rst_n_o; endproperty
  property p_ctrl_low;    s_rd_ctrl |=> rdata_o[5:0] == 6'h00; endproperty
  property p_stat_hi;     supply_ok_i [*3] ##0 s_rd_ctrl |=> rdata_o[6]; endproperty
  property p_stat_lo;     (!supply_ok_i) [*3] ##0 s_rd_ctrl |=> !rdata_o[6]; endproperty
  property p_unmapped;    rd_i && addr_i < 8'hef |=> rdata_o == 8'h00; endproperty
  property p_mask_off;
    wr_i && addr_i == 8'hf1 && wdata_i[2:0] == 3'h0 |=> !irq_o;
  endproperty

  a_drive_holds: assert property (p_drive_holds) else $error("core free, pin driven");
  a_pin_holds: assert property (p_pin_holds) else $error("core free, pin low");
  a_req_holds: assert property (p_req_holds) else $error("core free, request on");
  a_release: assert property (p_release) else $error("core held too long");
  a_ctrl_low: assert property (p_ctrl_low) else $error("unused bits set");
  a_stat_hi: assert property (p_stat_hi) else $error("status low");
  a_stat_lo: assert property (p_stat_lo) else $error("status high");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_mask_off: assert property (p_mask_off) else $error("irq with mask clear");
endmodule // reset_seq_props

bind reset_seq reset_seq_props u_props (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .supply_ok_i(supply_ok_i), .rst_pin_i(rst_pin_i),
  .sys_rst_req_i(sys_rst_req_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rst_pin_o(rst_pin_o), .rst_pin_oe_n_o(rst_pin_oe_n_o),
  .core_rst_n_o(core_rst_n_o), .rdata_o(rdata_o), .irq_o(irq_o)
);

`default_nettype wire

// >>> test/reset_partner.sv
`timescale 1ns/1ps
`default_nettype none

module reset_partner (
  // Clock
  input  wire logic mclk_i,
  // Bench requests
  input  wire logic supply_req_i,
  input  wire logic ext_low_i,
  // Device pin drive
  input  wire logic pin_drv_i,
  input  wire logic pin_oe_n_i,
  // Far side
  output var  logic supply_ok_o,
  output wire logic pin_o
);
  // Comparator answers one edge late, like a slow analogue path
  initial supply_ok_o = 1'b1;
  always @(posedge mclk_i) supply_ok_o <= supply_req_i;
  // Pulled-up wire: low if either party pulls
  assign pin_o = ~(ext_low_i | (~pin_oe_n_i & ~pin_drv_i));
endmodule // reset_partner

`default_nettype wire

// >>> test/tb_reset_seq.sv
`include "reset_seq_defs.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module tb_reset_seq;
  logic       mclk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       supply_req = 1'b1, ext_low = 1'b0, sys_rst_req_i = 1'b0;
  logic       wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, a;
  wire        supply_ok_i, rst_pin_i, rst_pin_o, rst_pin_oe_n_o, core_rst_n_o, irq_o;
  wire  [7:0] rdata_o;
  int         failures = 0, checked = 0, n, seed;

  always #5 mclk_i = ~mclk_i;

  reset_partner u_far (.mclk_i(mclk_i), .supply_req_i(supply_req), .ext_low_i(ext_low),
    .pin_drv_i(rst_pin_o), .pin_oe_n_i(rst_pin_oe_n_o), .supply_ok_o(supply_ok_i),
    .pin_o(rst_pin_i));

  // Short power-on count keeps the run brief
  reset_seq #(.POR_DELAY_CYC(8)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .supply_ok_i(supply_ok_i), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
    .rst_pin_oe_n_o(rst_pin_oe_n_o), .sys_rst_req_i(sys_rst_req_i),
    .core_rst_n_o(core_rst_n_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic [7:0] ctrl_exp(input logic en, input logic sup);
    return {en, sup, 6'h00};
  endfunction
  function automatic [7:0] cause_exp(input logic pwr, input logic pin);
    return {6'h00, pwr, pin};
  endfunction

  task automatic hold(input int c);
    repeat (c) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= ad; wdata_i <= d; wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge mclk_i);
    addr_i <= ad; rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    // Data launched at the strobe edge, taken before the next one moves it
    @(posedge mclk_i);
    `CHK(rdata_o, e)
  endtask
  task automatic wait_core(input int lim);
    n = 0;
    while (core_rst_n_o !== 1'b1 && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
    `CHK(core_rst_n_o, 1'b1)
    hold(2);
  endtask
  task automatic give_verdict;
    $display("Checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #50000;
    failures++;
    give_verdict;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    seed = $urandom(3108);
    hold(12);
    rst_n_i <= 1'b1;
    wait_core(40);
    rd(`ADDR_MON_CTRL, ctrl_exp(1'b1, 1'b1));
    rd(`ADDR_RST_CAUSE, cause_exp(1'b1, 1'b0));
    rd(`ADDR_IRQ_MASK, 8'h00);
    // Disabled monitor never resets
    wr(`ADDR_MON_CTRL, 8'h3f);
    rd(`ADDR_MON_CTRL, ctrl_exp(1'b0, 1'b1));
    supply_req <= 1'b0;
    hold(4);
    `CHK(core_rst_n_o, 1'b1)
    rd(`ADDR_MON_CTRL, ctrl_exp(1'b0, 1'b0));
    supply_req <= 1'b1;
    hold(4);
    // Enable, let it settle, then select
    wr(`ADDR_MON_CTRL, 8'h80);
    hold(3);
    wr(`ADDR_RST_CAUSE, 8'h02);
    supply_req <= 1'b0;
    hold(3);
    `CHK(core_rst_n_o, 1'b0)
    `CHK(rst_pin_i, 1'b0)
    `CHK(rst_pin_oe_n_o, 1'b0)
    `CHK(rst_pin_o, 1'b0)
    supply_req <= 1'b1;
    wait_core(6);
    rd(`ADDR_RST_CAUSE, cause_exp(1'b1, 1'b0));
    rd(`ADDR_IRQ_STAT, 8'h03);
    wr(`ADDR_IRQ_MASK, 8'h01);
    hold(1);
    `CHK(irq_o, 1'b1)
    wr(`ADDR_IRQ_MASK, 8'h00);
    hold(1);
    `CHK(irq_o, 1'b0)
    wr(`ADDR_IRQ_STAT, 8'h01);
    rd(`ADDR_IRQ_STAT, 8'h02);
    // External pin reset
    ext_low <= 1'b1;
    hold(6);
    `CHK(core_rst_n_o, 1'b0)
    `CHK(rst_pin_oe_n_o, 1'b1)
    ext_low <= 1'b0;
    wait_core(6);
    rd(`ADDR_RST_CAUSE, cause_exp(1'b0, 1'b1));
    rd(`ADDR_IRQ_STAT, 8'h06);
    // Other reset keeps a disabled monitor off
    wr(`ADDR_MON_CTRL, 8'h00);
    sys_rst_req_i <= 1'b1;
    hold(4);
    `CHK(core_rst_n_o, 1'b0)
    sys_rst_req_i <= 1'b0;
    wait_core(6);
    rd(`ADDR_MON_CTRL, ctrl_exp(1'b0, 1'b1));
    rd(`ADDR_RST_CAUSE, cause_exp(1'b0, 1'b0));
    // Random traffic to unmapped places
    repeat (40) begin
      a = 8'($urandom_range(238));
      wr(a, 8'($urandom));
      rd(a, 8'h00);
    end
    rd(`ADDR_MON_CTRL, ctrl_exp(1'b0, 1'b1));
    // Second power-on in mid-run
    rst_n_i <= 1'b0;
    hold(3);
    rst_n_i <= 1'b1;
    wait_core(40);
    rd(`ADDR_MON_CTRL, ctrl_exp(1'b1, 1'b1));
    rd(`ADDR_RST_CAUSE, cause_exp(1'b1, 1'b0));
    give_verdict;
  end
endmodule // tb_reset_seq

`default_nettype wire
